// ---- hw/board_glue_params.svh ----
// Purpose: Constants for the board glue logic and codec clock generator.
// Assumes: Single 250 MHz core clock.
// Notes: Offsets are bus byte offsets or processor I/O addresses.
`ifndef BOARD_GLUE_PARAMS_SVH
`define BOARD_GLUE_PARAMS_SVH
`define HOST_REG_BASE 8'h80
`define HOST_CTRL_OFS 8'h80
`define HOST_STAT_OFS 8'h84
`define HOST_REV_OFS 8'h88
`define HOST_SEM0_OFS 8'h8C
`define HOST_SEM1_OFS 8'h90
`define TBC_LAST_OFS 8'h5C
`define PROC_CTRL_ADR 3'h0
`define PROC_STAT_ADR 3'h1
`define PROC_PAGE_ADR 3'h2
`define PROC_DBIO_ADR 3'h3
`define PROC_CODEC_ADR 3'h4
`define PROC_CLKDIV_ADR 3'h5
`define PROC_SEM0_ADR 3'h6
`define PROC_SEM1_ADR 3'h7
`define MCLK_RATIO 10'd256
`define BCLK_PER_MCLK 3'd4
`define BITS_PER_FRAME 6'd63
`define CODEC_CTRL_RST 8'h00
`define CLKDIV_RST 8'h00
`define PAGE_RST 8'h20
`define REV_VALUE 8'h01
`endif

// ---- hw/board_glue_pkg.sv ----
// Purpose: Types for the board glue logic.
// Assumes: Nothing.
// Notes: Structs carry grouped bus signals.
package board_glue_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } gp_req_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } proc_req_t;
  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_LOW = 2'b01,
    XF_HIGH = 2'b11
  } xfer_state_t;
endpackage : board_glue_pkg

// ---- hw/board_glue_logic.sv ----
// Purpose: Board glue logic: codec clocks, bus decode, registers, resets, interrupts, semaphores.
// Assumes: All inputs synchronous to core_clk; source clocks enter as sampled enables.
// Notes: Codec clocks are produced as registered levels at core_clk resolution.
`timescale 1ns/100ps
`default_nettype none
`include "board_glue_params.svh"
module board_glue_logic
  import board_glue_pkg::*;
#(
  parameter int DIV_W = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic src_a_tick,
  input wire logic src_b_tick,
  input wire gp_req_t gp_req,
  output logic [15:0] gp_rdata,
  output logic scan_rd,
  output logic scan_wr,
  input wire proc_req_t proc_req,
  output logic [7:0] proc_rdata,
  input wire logic bridge_rst_req,
  input wire logic button_rst_req,
  input wire logic supply_rst_req,
  output logic proc_rst,
  output logic dboard_rst,
  output logic scan_rst,
  input wire logic dboard_irq,
  output logic host_irq,
  output logic proc_nmi,
  output logic proc_irq3,
  input wire logic [7:0] dboard_gpio_in,
  output logic [7:0] dboard_gpio_out,
  input wire logic dboard_wide_acc,
  input wire logic dboard_rd,
  input wire logic dboard_wr,
  output logic xcvr_latch_up,
  output logic xcvr_oe_up,
  output logic xcvr_hi_sel,
  output logic codec_mclk,
  output logic codec_bclk,
  output logic codec_frame,
  output logic codec_en
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] host_ctrl_ff, proc_ctrl_ff, page_ff, codec_ff, clkdiv_ff;
  logic sem0_ff, sem1_ff, sem0_host_ff, sem1_host_ff;
  logic host_irq_req_ff, dsp_irq_req_ff;
  logic [2:0] rst_cnt_ff;
  logic [DIV_W-1:0] div_cnt_ff;
  logic [2:0] bclk_cnt_ff;
  logic [5:0] bit_cnt_ff;
  xfer_state_t xf_ff;

  function automatic logic hit_host(input gp_req_t r, input logic [7:0] ofs);
    hit_host = r.addr[7] && (r.addr == ofs);
  endfunction : hit_host

  function automatic logic hit_proc(input proc_req_t r, input logic [2:0] a);
    hit_proc = r.addr == a;
  endfunction : hit_proc

  wire logic glue_wr = gp_req.wr && gp_req.addr[7];
  wire logic proc_wr = proc_req.wr;

  // ****************************************
  // Bus decode to scan controller
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scan_rd <= 1'b0;
      scan_wr <= 1'b0;
    end else begin
      scan_rd <= gp_req.rd && !gp_req.addr[7] && (gp_req.addr <= `TBC_LAST_OFS);
      scan_wr <= gp_req.wr && !gp_req.addr[7] && (gp_req.addr <= `TBC_LAST_OFS);
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_ctrl_ff <= 8'h00;
      proc_ctrl_ff <= 8'h00;
      page_ff <= `PAGE_RST;
      codec_ff <= `CODEC_CTRL_RST;
      clkdiv_ff <= `CLKDIV_RST;
      dboard_gpio_out <= 8'h00;
    end else begin
      if (glue_wr && hit_host(gp_req, `HOST_CTRL_OFS)) host_ctrl_ff <= gp_req.wdata[7:0];
      if (proc_wr && hit_proc(proc_req, `PROC_CTRL_ADR)) proc_ctrl_ff <= proc_req.wdata;
      if (proc_wr && hit_proc(proc_req, `PROC_PAGE_ADR)) page_ff <= proc_req.wdata;
      if (proc_wr && hit_proc(proc_req, `PROC_DBIO_ADR)) dboard_gpio_out <= proc_req.wdata;
      if (proc_wr && hit_proc(proc_req, `PROC_CODEC_ADR)) codec_ff <= proc_req.wdata;
      if (proc_wr && hit_proc(proc_req, `PROC_CLKDIV_ADR)) clkdiv_ff <= proc_req.wdata;
    end
  end

  // ****************************************
  // Semaphores
  // ****************************************
  // A read of a free semaphore grants it to the reader; a write by its holder frees it.
  // A host read in the same cycle wins, so the processor must see the semaphore taken.
  wire logic host_take0 = gp_req.rd && hit_host(gp_req, `HOST_SEM0_OFS);
  wire logic host_take1 = gp_req.rd && hit_host(gp_req, `HOST_SEM1_OFS);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sem0_ff <= 1'b0;
      sem1_ff <= 1'b0;
      sem0_host_ff <= 1'b0;
      sem1_host_ff <= 1'b0;
    end else begin
      if (!sem0_ff && gp_req.rd && hit_host(gp_req, `HOST_SEM0_OFS)) begin
        sem0_ff <= 1'b1;
        sem0_host_ff <= 1'b1;
      end else if (!sem0_ff && proc_req.rd && hit_proc(proc_req, `PROC_SEM0_ADR)) begin
        sem0_ff <= 1'b1;
        sem0_host_ff <= 1'b0;
      end else if ((glue_wr && hit_host(gp_req, `HOST_SEM0_OFS) && sem0_host_ff) ||
                   (proc_wr && hit_proc(proc_req, `PROC_SEM0_ADR) && !sem0_host_ff)) begin
        sem0_ff <= 1'b0;
      end
      if (!sem1_ff && gp_req.rd && hit_host(gp_req, `HOST_SEM1_OFS)) begin
        sem1_ff <= 1'b1;
        sem1_host_ff <= 1'b1;
      end else if (!sem1_ff && proc_req.rd && hit_proc(proc_req, `PROC_SEM1_ADR)) begin
        sem1_ff <= 1'b1;
        sem1_host_ff <= 1'b0;
      end else if ((glue_wr && hit_host(gp_req, `HOST_SEM1_OFS) && sem1_host_ff) ||
                   (proc_wr && hit_proc(proc_req, `PROC_SEM1_ADR) && !sem1_host_ff)) begin
        sem1_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gp_rdata <= 16'h0000;
    end else if (gp_req.rd && gp_req.addr[7]) begin
      case (gp_req.addr)
        `HOST_CTRL_OFS: gp_rdata <= {8'h00, host_ctrl_ff};
        `HOST_STAT_OFS: gp_rdata <= {12'h000, dboard_irq, dsp_irq_req_ff, host_irq_req_ff, proc_rst};
        `HOST_REV_OFS: gp_rdata <= {8'h00, `REV_VALUE};
        `HOST_SEM0_OFS: gp_rdata <= {15'h0000, sem0_ff};
        `HOST_SEM1_OFS: gp_rdata <= {15'h0000, sem1_ff};
        default: gp_rdata <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      proc_rdata <= 8'h00;
    end else if (proc_req.rd) begin
      case (proc_req.addr)
        `PROC_CTRL_ADR: proc_rdata <= proc_ctrl_ff;
        `PROC_STAT_ADR: proc_rdata <= {5'h00, dboard_irq, host_irq_req_ff, dsp_irq_req_ff};
        `PROC_PAGE_ADR: proc_rdata <= page_ff;
        `PROC_DBIO_ADR: proc_rdata <= dboard_gpio_in;
        `PROC_CODEC_ADR: proc_rdata <= codec_ff;
        `PROC_CLKDIV_ADR: proc_rdata <= clkdiv_ff;
        `PROC_SEM0_ADR: proc_rdata <= {7'h00, sem0_ff || host_take0};
        default: proc_rdata <= {7'h00, sem1_ff || host_take1};
      endcase
    end
  end

  // ****************************************
  // Resets
  // ****************************************
  // Any request restarts a short stretch so a one-cycle request is not lost.
  wire logic any_rst = bridge_rst_req | button_rst_req | supply_rst_req | host_ctrl_ff[0] | proc_ctrl_ff[0];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_cnt_ff <= 3'h7;
      proc_rst <= 1'b1;
      dboard_rst <= 1'b1;
      scan_rst <= 1'b1;
    end else begin
      rst_cnt_ff <= any_rst ? 3'h7 : (rst_cnt_ff != 3'h0 ? rst_cnt_ff - 3'h1 : 3'h0);
      proc_rst <= any_rst || (rst_cnt_ff != 3'h0);
      dboard_rst <= any_rst || (rst_cnt_ff != 3'h0) || proc_ctrl_ff[1];
      scan_rst <= bridge_rst_req || supply_rst_req || host_ctrl_ff[1];
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Host control bit 2 raises a processor request, processor bit 2 a host request.
  // A new request wins over a clear in the same cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_irq_req_ff <= 1'b0;
      dsp_irq_req_ff <= 1'b0;
      host_irq <= 1'b0;
      proc_nmi <= 1'b0;
      proc_irq3 <= 1'b0;
    end else begin
      if (proc_wr && hit_proc(proc_req, `PROC_CTRL_ADR) && proc_req.wdata[2]) host_irq_req_ff <= 1'b1;
      else if (glue_wr && hit_host(gp_req, `HOST_STAT_OFS) && gp_req.wdata[1]) host_irq_req_ff <= 1'b0;
      if (glue_wr && hit_host(gp_req, `HOST_CTRL_OFS) && gp_req.wdata[2]) dsp_irq_req_ff <= 1'b1;
      else if (proc_wr && hit_proc(proc_req, `PROC_STAT_ADR) && proc_req.wdata[0]) dsp_irq_req_ff <= 1'b0;
      host_irq <= host_irq_req_ff && host_ctrl_ff[3];
      proc_nmi <= dsp_irq_req_ff && proc_ctrl_ff[3] && host_ctrl_ff[4];
      proc_irq3 <= proc_ctrl_ff[5] ? (dboard_irq && proc_ctrl_ff[4]) : (dsp_irq_req_ff && proc_ctrl_ff[4]);
    end
  end

  // ****************************************
  // Upper data transceiver
  // ****************************************
  // A wide access moves two halves: low half first, upper half from the latch.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xf_ff <= XF_IDLE;
      xcvr_latch_up <= 1'b0;
      xcvr_oe_up <= 1'b0;
      xcvr_hi_sel <= 1'b0;
    end else begin
      case (xf_ff)
        XF_IDLE: begin
          xcvr_latch_up <= 1'b0;
          xcvr_oe_up <= 1'b0;
          xcvr_hi_sel <= 1'b0;
          if (dboard_wide_acc && (dboard_rd || dboard_wr)) begin
            xf_ff <= XF_LOW;
            xcvr_latch_up <= 1'b1;
          end
        end
        XF_LOW: begin
          xcvr_latch_up <= 1'b0;
          if (dboard_rd || dboard_wr) begin
            xf_ff <= XF_HIGH;
            xcvr_hi_sel <= 1'b1;
            xcvr_oe_up <= 1'b1;
          end
        end
        XF_HIGH: begin
          xf_ff <= XF_IDLE;
          xcvr_hi_sel <= 1'b0;
          xcvr_oe_up <= 1'b0;
        end
        default: xf_ff <= XF_IDLE;
      endcase
    end
  end

  // ****************************************
  // Codec clocks
  // ****************************************
  // Codec register: bit0 clocks on, bit1 codec enabled. Clock register:
  // bit7 source select, bits DIV_W-1:0 half-period in source ticks minus one.
  wire logic src_tick = clkdiv_ff[7] ? src_b_tick : src_a_tick;
  wire logic clk_on = codec_ff[0];
  wire logic mclk_edge = clk_on && src_tick && (div_cnt_ff == clkdiv_ff[DIV_W-1:0]);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_ff <= '0;
      codec_mclk <= 1'b0;
      codec_en <= 1'b0;
    end else begin
      codec_en <= codec_ff[1];
      if (!clk_on) begin
        div_cnt_ff <= '0;
        codec_mclk <= 1'b0;
      end else if (src_tick) begin
        div_cnt_ff <= mclk_edge ? '0 : div_cnt_ff + 1'b1;
        if (mclk_edge) codec_mclk <= ~codec_mclk;
      end
    end
  end

  // Bit clock toggles every 2 master periods, i.e. master/4 with equal halves.
  wire logic mclk_fall = mclk_edge && codec_mclk;
  wire logic bclk_edge = mclk_fall && bclk_cnt_ff[0];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bclk_cnt_ff <= 3'h0;
      codec_bclk <= 1'b0;
      bit_cnt_ff <= 6'h00;
      codec_frame <= 1'b0;
    end else if (!clk_on) begin
      bclk_cnt_ff <= 3'h0;
      codec_bclk <= 1'b0;
      bit_cnt_ff <= 6'h00;
      codec_frame <= 1'b0;
    end else if (bclk_edge) begin
      bclk_cnt_ff <= 3'h0;
      codec_bclk <= ~codec_bclk;
      if (!codec_bclk) begin
        // Frame changes only on rising bit clock so it spans one bit period.
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
        codec_frame <= (bit_cnt_ff == `BITS_PER_FRAME);
      end
    end else if (mclk_fall) begin
      bclk_cnt_ff <= bclk_cnt_ff + 3'h1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  scan_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    scan_rd |-> $past(!gp_req.addr[7] && gp_req.rd)) else $error("scan read without low address");
  glue_claim_a: assert property (@(posedge core_clk) disable iff (rst)
    (gp_req.addr[7] && (gp_req.rd || gp_req.wr)) |=> !scan_rd && !scan_wr) else $error("glue access leaked");
  frame_one_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(codec_frame) |-> codec_bclk) else $error("frame not on rising bit clock");
  frame_launch_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(codec_frame) && clk_on |-> $rose(codec_bclk)) else $error("frame moved off rising edge");
  mclk_off_a: assert property (@(posedge core_clk) disable iff (rst)
    !codec_ff[0] |=> !codec_mclk && !codec_bclk) else $error("clocks run while disabled");
  bclk_sync_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(codec_bclk) && clk_on |-> $fell(codec_mclk)) else $error("bit clock off master edge");
  rev_read_a: assert property (@(posedge core_clk) disable iff (rst)
    (gp_req.rd && gp_req.addr == `HOST_REV_OFS) |=> gp_rdata == {8'h00, `REV_VALUE}) else $error("bad revision");
  sem_grant_a: assert property (@(posedge core_clk) disable iff (rst)
    (!sem0_ff && proc_req.rd && proc_req.addr == `PROC_SEM0_ADR && !(gp_req.rd && gp_req.addr == `HOST_SEM0_OFS))
    |=> sem0_ff && !sem0_host_ff) else $error("semaphore not granted");
  rst_merge_a: assert property (@(posedge core_clk) disable iff (rst)
    button_rst_req |=> proc_rst ##1 proc_rst) else $error("reset not stretched");
  codec_en_a: assert property (@(posedge core_clk) disable iff (rst)
    codec_en == $past(codec_ff[1])) else $error("codec enable lag");

endmodule : board_glue_logic
`default_nettype wire

// ---- verif/codec_port_model.sv ----
// Purpose: Model of the codec and processor serial port on the far side of the codec clocks.
// Assumes: Bit clock and frame clock come from the glue logic.
// Notes: The model loops its own word back so that framing faults corrupt the received word.
`timescale 1ns/100ps
`default_nettype none
module codec_port_model #(
  parameter logic [15:0] TX_WORD = 16'hA5C3
) (
  input wire logic codec_bclk,
  input wire logic codec_frame,
  input wire logic codec_en,
  output logic [15:0] rx_word,
  output logic [7:0] frames
);
  logic sdata_ff;
  logic [5:0] idx_ff;
  logic [15:0] shift_ff;
  logic [5:0] nxt_idx;

  initial begin
    sdata_ff = 1'b0;
    idx_ff = 6'h3F;
    shift_ff = 16'h0000;
    rx_word = 16'h0000;
    frames = 8'h00;
  end

  assign nxt_idx = idx_ff + 6'h01;

  // Launch on the rising edge; outside the word the line toggles as released.
  always @(posedge codec_bclk) begin
    if (codec_en && nxt_idx < 6'h10) begin
      sdata_ff <= TX_WORD[4'hF - nxt_idx[3:0]];
    end else begin
      sdata_ff <= ~sdata_ff;
    end
  end

  // Sample on the falling edge; a high frame marks the first bit.
  always @(negedge codec_bclk) begin
    idx_ff <= codec_frame ? 6'h00 : nxt_idx;
    shift_ff <= codec_frame ? {15'h0000, sdata_ff} : {shift_ff[14:0], sdata_ff};
    if (!codec_frame && idx_ff == 6'h0E) begin
      rx_word <= {shift_ff[14:0], sdata_ff};
      frames <= frames + 8'h01;
    end
  end
endmodule : codec_port_model
`default_nettype wire

// ---- verif/board_glue_logic_tb.sv ----
// Purpose: Self-checking bench for the board glue logic.
// Assumes: Source clocks are modelled as ticks with whole-cycle periods.
// Notes: Measured clock phases are counted in core cycles.
`timescale 1ns/100ps
`default_nettype none
`include "board_glue_params.svh"
module board_glue_logic_tb
  import board_glue_pkg::*;
;
  localparam int PER_A = 10;
  localparam int PER_B = 7;
  localparam logic [15:0] TX_WORD = 16'hA5C3;
  logic core_clk, rst, src_a_tick, src_b_tick, bridge_rst_req, button_rst_req, supply_rst_req;
  logic dboard_irq, dboard_wide_acc, dboard_rd, dboard_wr, scan_rd, scan_wr, proc_rst, dboard_rst;
  logic scan_rst, host_irq, proc_nmi, proc_irq3, xcvr_latch_up, xcvr_oe_up, xcvr_hi_sel;
  logic codec_mclk, codec_bclk, codec_frame, codec_en;
  logic [15:0] gp_rdata, rx_word;
  logic [7:0] proc_rdata, dboard_gpio_in, dboard_gpio_out, frames;
  gp_req_t gp_req;
  proc_req_t proc_req;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int cnt_a = 0;
  int cnt_b = 0;

  board_glue_logic #(.DIV_W(4)) board_glue_logic_i (.core_clk, .rst, .src_a_tick, .src_b_tick, .gp_req,
    .gp_rdata, .scan_rd, .scan_wr, .proc_req, .proc_rdata, .bridge_rst_req, .button_rst_req, .supply_rst_req,
    .proc_rst, .dboard_rst, .scan_rst, .dboard_irq, .host_irq, .proc_nmi, .proc_irq3, .dboard_gpio_in,
    .dboard_gpio_out, .dboard_wide_acc, .dboard_rd, .dboard_wr, .xcvr_latch_up, .xcvr_oe_up, .xcvr_hi_sel,
    .codec_mclk, .codec_bclk, .codec_frame, .codec_en);

  codec_port_model #(.TX_WORD(TX_WORD)) codec_port_model_i (.codec_bclk, .codec_frame, .codec_en, .rx_word,
    .frames);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Periodic source ticks and the run-time ceiling.
  always @(posedge core_clk) begin
    #1;
    cnt_a = (cnt_a + 1) % PER_A;
    cnt_b = (cnt_b + 1) % PER_B;
    src_a_tick = (cnt_a == 0);
    src_b_tick = (cnt_b == 0);
    cyc = cyc + 1;
    if (cyc == 80000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic host_op(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
      output logic [15:0] rdata);
    step();
    gp_req = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    step();
    gp_req = '0;
    rdata = gp_rdata;
  endtask : host_op

  task automatic proc_op(input logic wr, input logic [2:0] addr, input logic [7:0] wdata,
      output logic [7:0] rdata);
    step();
    proc_req = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    step();
    proc_req = '0;
    rdata = proc_rdata;
  endtask : proc_op

  function automatic logic pick(input int sel);
    return sel == 0 ? codec_mclk : (sel == 1 ? codec_bclk : codec_frame);
  endfunction : pick

  // Counts one full high phase and the low phase after it.
  task automatic measure(input int sel, output int hi, output int lo);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (pick(sel) !== 1'b0 && n < 20000) begin step(); n++; end
    while (pick(sel) !== 1'b1 && n < 20000) begin step(); n++; end
    while (pick(sel) === 1'b1 && n < 20000) begin step(); n++; hi++; end
    while (pick(sel) === 1'b0 && n < 20000) begin step(); n++; lo++; end
  endtask : measure

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic test_reset();
    check_bit(proc_rst & dboard_rst & scan_rst, 1'b1);
    check_bit(codec_en | codec_mclk, 1'b0);
    rst = 1'b0;
    step();
    check_bit(scan_rst, 1'b0);
    repeat (20) step();
    check_bit(proc_rst | dboard_rst, 1'b0);
    for (int i = 0; i < 3; i++) begin
      {bridge_rst_req, button_rst_req, supply_rst_req} = 3'b100 >> i;
      repeat (3) step();
      check_bit(proc_rst, 1'b1);
      {bridge_rst_req, button_rst_req, supply_rst_req} = 3'b000;
      repeat (20) step();
      check_bit(proc_rst, 1'b0);
    end
  endtask : test_reset

  task automatic test_decode();
    logic [15:0] d;
    host_op(1'b1, 8'h00, 16'h1234, d);
    check_bit(scan_wr, 1'b1);
    step();
    check_bit(scan_wr, 1'b0);
    host_op(1'b0, `TBC_LAST_OFS, 16'h0000, d);
    check_bit(scan_rd, 1'b1);
    host_op(1'b0, 8'h60, 16'h0000, d);
    check_bit(scan_rd, 1'b0);
    host_op(1'b1, `HOST_REV_OFS, 16'h00FF, d);
    check_bit(scan_wr, 1'b0);
    host_op(1'b0, `HOST_REV_OFS, 16'h0000, d);
    check_bit(scan_rd, 1'b0);
    check_val(d & 16'h00FF, {8'h00, `REV_VALUE});
    host_op(1'b0, 8'h94, 16'h0000, d);
    check_val(d, 16'h0000);
  endtask : test_decode

  task automatic test_proc_regs();
    logic [7:0] r;
    proc_op(1'b0, `PROC_PAGE_ADR, 8'h00, r);
    check_val({8'h00, r}, {8'h00, `PAGE_RST});
    proc_op(1'b0, `PROC_CLKDIV_ADR, 8'h00, r);
    check_val({8'h00, r}, {8'h00, `CLKDIV_RST});
    proc_op(1'b1, `PROC_DBIO_ADR, 8'h5A, r);
    check_val({8'h00, dboard_gpio_out}, 16'h005A);
  endtask : test_proc_regs

  task automatic test_sema();
    logic [15:0] d;
    logic [7:0] r;
    host_op(1'b0, `HOST_SEM0_OFS, 16'h0000, d);
    check_val(d & 16'h0001, 16'h0000);
    proc_op(1'b0, `PROC_SEM0_ADR, 8'h00, r);
    check_val({8'h00, r & 8'h01}, 16'h0001);
    proc_op(1'b1, `PROC_SEM0_ADR, 8'h00, r);
    host_op(1'b0, `HOST_SEM0_OFS, 16'h0000, d);
    check_val(d & 16'h0001, 16'h0001);
    host_op(1'b1, `HOST_SEM0_OFS, 16'h0000, d);
    proc_op(1'b0, `PROC_SEM0_ADR, 8'h00, r);
    check_val({8'h00, r & 8'h01}, 16'h0000);
    step();
    gp_req = '{rd: 1'b1, wr: 1'b0, addr: `HOST_SEM1_OFS, wdata: 16'h0000};
    proc_req = '{rd: 1'b1, wr: 1'b0, addr: `PROC_SEM1_ADR, wdata: 8'h00};
    step();
    gp_req = '0;
    proc_req = '0;
    check_val(gp_rdata & 16'h0001, 16'h0000);
    check_val({8'h00, proc_rdata & 8'h01}, 16'h0001);
  endtask : test_sema

  task automatic test_irq();
    logic [15:0] d;
    logic [7:0] r;
    host_op(1'b1, `HOST_CTRL_OFS, 16'h0008, d);
    proc_op(1'b1, `PROC_CTRL_ADR, 8'h34, r);
    dboard_irq = 1'b1;
    repeat (3) step();
    check_bit(proc_irq3, 1'b1);
    check_bit(host_irq, 1'b1);
    dboard_irq = 1'b0;
    host_op(1'b1, `HOST_CTRL_OFS, 16'h0000, d);
    repeat (3) step();
    check_bit(proc_irq3 | host_irq, 1'b0);
    host_op(1'b1, `HOST_CTRL_OFS, 16'h0014, d);
    proc_op(1'b1, `PROC_CTRL_ADR, 8'h08, r);
    repeat (2) step();
    check_bit(proc_nmi, 1'b1);
    proc_op(1'b1, `PROC_STAT_ADR, 8'h01, r);
    repeat (2) step();
    check_bit(proc_nmi, 1'b0);
  endtask : test_irq

  task automatic test_xcvr();
    {dboard_wide_acc, dboard_rd, dboard_wr} = 3'b110;
    step();
    check_bit(xcvr_latch_up, 1'b1);
    step();
    {dboard_wide_acc, dboard_rd, dboard_wr} = 3'b000;
    check_bit(xcvr_hi_sel & xcvr_oe_up & !xcvr_latch_up, 1'b1);
    step();
    check_bit(xcvr_hi_sel | xcvr_oe_up | xcvr_latch_up, 1'b0);
  endtask : test_xcvr

  task automatic test_clocks(input logic src_b, input logic [3:0] n);
    logic [7:0] r;
    int per, hi, lo, f0;
    per = (src_b ? PER_B : PER_A) * (n + 1);
    proc_op(1'b1, `PROC_CLKDIV_ADR, {src_b, 3'h0, n}, r);
    proc_op(1'b1, `PROC_CODEC_ADR, 8'h03, r);
    step();
    check_bit(codec_en, 1'b1);
    repeat (300) step();
    measure(0, hi, lo);
    check_val(16'(hi), 16'(per));
    check_val(16'(lo), 16'(per));
    measure(1, hi, lo);
    check_val(16'(hi), 16'(4 * per));
    check_val(16'(lo), 16'(4 * per));
    measure(2, hi, lo);
    check_val(16'(hi), 16'(8 * per));
    check_val(16'(hi + lo), 16'(512 * per));
    f0 = frames;
    for (int i = 0; i < 20000 && frames != 8'(f0 + 2); i++) step();
    check_val(rx_word, TX_WORD);
  endtask : test_clocks

  task automatic test_off();
    logic [7:0] r;
    logic m;
    int c;
    c = 0;
    proc_op(1'b1, `PROC_CODEC_ADR, 8'h00, r);
    repeat (2) step();
    check_bit(codec_en, 1'b0);
    m = codec_mclk;
    repeat (100) begin step(); if (codec_mclk !== m) c++; end
    check_val(16'(c), 16'h0000);
  endtask : test_off

  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    rst = 1'b1;
    src_a_tick = 1'b0;
    src_b_tick = 1'b0;
    gp_req = '0;
    proc_req = '0;
    {bridge_rst_req, button_rst_req, supply_rst_req} = 3'b000;
    dboard_irq = 1'b0;
    dboard_gpio_in = 8'h3C;
    {dboard_wide_acc, dboard_rd, dboard_wr} = 3'b000;
    repeat (5) step();
    test_reset();
    test_decode();
    test_proc_regs();
    test_sema();
    test_irq();
    test_xcvr();
    test_clocks(1'b0, 4'h0);
    test_clocks(1'b1, 4'h1);
    test_off();
    finish_test();
  end
endmodule : board_glue_logic_tb
`default_nettype wire
